/* rtl/nvmwp_ctrl.sv */
// write control and protection for data EEPROM and self-programmable flash
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
module nvmwp_ctrl #(
  parameter int PWRT_CYCLES = nvmwp_pkg::PWRT_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register port
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // configuration word
  input wire logic cfg_data_protect,
  input wire logic cfg_code_protect,
  input wire logic [1:0] self_write_protect_bits,
  // memory array side
  input wire logic mem_done,
  input wire logic mem_rd_valid,
  input wire logic [13:0] mem_rd_data,
  output logic mem_ee_write,
  output logic mem_flash_write,
  output logic mem_erase,
  output logic mem_read,
  output logic mem_is_program,
  output logic mem_active,
  output logic [10:0] mem_addr,
  output logic [13:0] mem_data,
  output logic [55:0] mem_block_data,
  // external programming pins
  input wire logic ext_req,
  input wire logic ext_is_write,
  input wire logic ext_is_program,
  output logic ext_grant,
  output logic ext_deny,
  // interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] data_lo;
    logic [7:0] addr_lo;
    logic [5:0] data_hi;
    logic [2:0] addr_hi;
    logic pgm_sel;
    logic erase_sel;
    logic wr_err;
    logic wr_en;
    logic wr_start;
    logic rd_start;
    nvmwp_pkg::nvmwp_unlock_type unlock;
    nvmwp_pkg::nvmwp_op_type op;
    logic long_op;
    logic [3:0][13:0] buf_words;
    logic [22:0] pwrt_cnt;
    logic pwrt_done;
    logic done_flag;
    logic done_en;
    logic irq;
    logic [7:0] rdata;
    logic ee_wr;
    logic fl_wr;
    logic erase;
    logic rd_req;
    logic active;
    logic [10:0] m_addr;
    logic [13:0] m_data;
    logic [2:0] ext_s1;
    logic [2:0] ext_s2;
    logic grant;
    logic deny;
  } nvmwp_state_type;

  nvmwp_state_type st_ff;
  nvmwp_state_type nxt_st;

  logic [10:0] full_addr;
  logic [10:0] prot_limit;
  logic self_blocked;
  logic ctl_wr;
  logic launch_ok;
  logic done_event;
  logic ext_rq;
  logic ext_w;
  logic ext_p;

  assign full_addr = {st_ff.addr_hi, st_ff.addr_lo};
  assign ctl_wr = reg_wr && reg_addr == nvmwp_pkg::OFS_CONTROL;
  assign ext_rq = st_ff.ext_s2[0];
  assign ext_w = st_ff.ext_s2[1];
  assign ext_p = st_ff.ext_s2[2];

  // protected region below a limit picked by the configuration bits
  always_comb begin
    unique case (self_write_protect_bits)
      nvmwp_pkg::WRT_NONE: prot_limit = '0;
      nvmwp_pkg::WRT_LOW: prot_limit = nvmwp_pkg::LIMIT_LOW;
      nvmwp_pkg::WRT_MID: prot_limit = nvmwp_pkg::LIMIT_MID;
      default: prot_limit = nvmwp_pkg::LIMIT_ALL;
    endcase
  end
  // LIMIT_ALL covers the top word too
  assign self_blocked = self_write_protect_bits != nvmwp_pkg::WRT_NONE &&
                        (full_addr < prot_limit || prot_limit == nvmwp_pkg::LIMIT_ALL);

  // refused if not unlocked, not enabled, busy, timer running (data EEPROM) or region protected (program memory)
  assign launch_ok = st_ff.unlock == nvmwp_pkg::UNL_ARMED && st_ff.wr_en &&
                     st_ff.op == nvmwp_pkg::OP_IDLE &&
                     !(!st_ff.pgm_sel && !st_ff.pwrt_done) &&
                     !(st_ff.pgm_sel && self_blocked);

  assign done_event = st_ff.op == nvmwp_pkg::OP_WAIT && mem_done;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ee_wr = 1'b0;
    nxt_st.fl_wr = 1'b0;
    nxt_st.erase = 1'b0;
    nxt_st.rd_req = 1'b0;
    nxt_st.rdata = '0;
    nxt_st.ext_s1 = {ext_is_program, ext_is_write, ext_req};
    nxt_st.ext_s2 = st_ff.ext_s1;

    if (st_ff.pwrt_cnt == nvmwp_pkg::PWRT_W'(PWRT_CYCLES - 1)) begin
      nxt_st.pwrt_done = 1'b1;
    end else begin
      nxt_st.pwrt_cnt = st_ff.pwrt_cnt + 1'b1;
    end

    // register reads, one cycle later
    if (reg_rd) begin
      unique case (reg_addr)
        nvmwp_pkg::OFS_IRQ_FLAGS: nxt_st.rdata[nvmwp_pkg::BIT_DONE] = st_ff.done_flag;
        nvmwp_pkg::OFS_IRQ_EN: nxt_st.rdata[nvmwp_pkg::BIT_DONE] = st_ff.done_en;
        nvmwp_pkg::OFS_DATA_LO: nxt_st.rdata = st_ff.data_lo;
        nvmwp_pkg::OFS_ADDR_LO: nxt_st.rdata = st_ff.addr_lo;
        nvmwp_pkg::OFS_DATA_HI: nxt_st.rdata = {2'h0, st_ff.data_hi};
        nvmwp_pkg::OFS_ADDR_HI: nxt_st.rdata = {5'h00, st_ff.addr_hi};
        nvmwp_pkg::OFS_CONTROL: begin
          nxt_st.rdata[nvmwp_pkg::BIT_PGM_SEL] = st_ff.pgm_sel;
          nxt_st.rdata[nvmwp_pkg::BIT_ERASE] = st_ff.erase_sel;
          nxt_st.rdata[nvmwp_pkg::BIT_WR_ERR] = st_ff.wr_err;
          nxt_st.rdata[nvmwp_pkg::BIT_WR_EN] = st_ff.wr_en;
          nxt_st.rdata[nvmwp_pkg::BIT_WR_START] = st_ff.wr_start;
          nxt_st.rdata[nvmwp_pkg::BIT_RD_START] = st_ff.rd_start;
        end
        default: nxt_st.rdata = '0;
      endcase
      // reading the flag register clears it; a done event below still wins
      if (reg_addr == nvmwp_pkg::OFS_IRQ_FLAGS) begin
        nxt_st.done_flag = 1'b0;
      end
    end

    if (reg_wr) begin
      unique case (reg_addr)
        nvmwp_pkg::OFS_IRQ_FLAGS: nxt_st.done_flag = reg_wdata[nvmwp_pkg::BIT_DONE];
        nvmwp_pkg::OFS_IRQ_EN: nxt_st.done_en = reg_wdata[nvmwp_pkg::BIT_DONE];
        nvmwp_pkg::OFS_DATA_LO: nxt_st.data_lo = reg_wdata;
        nvmwp_pkg::OFS_ADDR_LO: nxt_st.addr_lo = reg_wdata;
        nvmwp_pkg::OFS_DATA_HI: nxt_st.data_hi = reg_wdata[nvmwp_pkg::DATA_HI_W-1:0];
        nvmwp_pkg::OFS_ADDR_HI: nxt_st.addr_hi = reg_wdata[nvmwp_pkg::ADDR_HI_W-1:0];
        nvmwp_pkg::OFS_CONTROL: begin
          nxt_st.pgm_sel = reg_wdata[nvmwp_pkg::BIT_PGM_SEL];
          nxt_st.erase_sel = reg_wdata[nvmwp_pkg::BIT_ERASE];
          nxt_st.wr_err = reg_wdata[nvmwp_pkg::BIT_WR_ERR];
          nxt_st.wr_en = reg_wdata[nvmwp_pkg::BIT_WR_EN];
        end
        default: nxt_st.data_lo = st_ff.data_lo;
      endcase
      // any write breaks the unlock chain except its own next step
      if (reg_addr == nvmwp_pkg::OFS_UNLOCK) begin
        if (reg_wdata == nvmwp_pkg::KEY_FIRST) begin
          nxt_st.unlock = nvmwp_pkg::UNL_FIRST;
        end else if (reg_wdata == nvmwp_pkg::KEY_SECOND && st_ff.unlock == nvmwp_pkg::UNL_FIRST) begin
          nxt_st.unlock = nvmwp_pkg::UNL_ARMED;
        end else begin
          nxt_st.unlock = nvmwp_pkg::UNL_IDLE;
        end
      end else begin
        nxt_st.unlock = nvmwp_pkg::UNL_IDLE;
      end
    end

    // write start: launched or refused, never left pending
    if (ctl_wr && reg_wdata[nvmwp_pkg::BIT_WR_START] && !st_ff.wr_start) begin
      if (launch_ok) begin
        nxt_st.wr_start = 1'b1;
        nxt_st.m_addr = full_addr;
        nxt_st.m_data = {st_ff.data_hi, st_ff.data_lo};
        nxt_st.long_op = 1'b0;
        if (!st_ff.pgm_sel) begin
          nxt_st.ee_wr = 1'b1;
          nxt_st.op = nvmwp_pkg::OP_WAIT;
        end else if (st_ff.erase_sel) begin
          nxt_st.erase = 1'b1;
          nxt_st.op = nvmwp_pkg::OP_WAIT;
        end else begin
          nxt_st.buf_words[st_ff.addr_lo[1:0]] = {st_ff.data_hi, st_ff.data_lo};
          if (st_ff.addr_lo[1:0] == nvmwp_pkg::LAST_IN_BLOCK) begin
            nxt_st.fl_wr = 1'b1;
            nxt_st.long_op = 1'b1;
            nxt_st.op = nvmwp_pkg::OP_WAIT;
          end else begin
            nxt_st.op = nvmwp_pkg::OP_SHORT;
          end
        end
      end else begin
        // hardware set wins over the software value written this cycle
        nxt_st.wr_err = 1'b1;
      end
    end else if (ctl_wr && reg_wdata[nvmwp_pkg::BIT_RD_START] && st_ff.op == nvmwp_pkg::OP_IDLE) begin
      nxt_st.rd_start = 1'b1;
      nxt_st.rd_req = 1'b1;
      nxt_st.m_addr = full_addr;
      nxt_st.op = nvmwp_pkg::OP_READ;
    end

    unique case (st_ff.op)
      nvmwp_pkg::OP_SHORT: begin
        nxt_st.wr_start = 1'b0;
        nxt_st.op = nvmwp_pkg::OP_IDLE;
      end
      nvmwp_pkg::OP_WAIT: begin
        if (mem_done) begin
          nxt_st.wr_start = 1'b0;
          nxt_st.op = nvmwp_pkg::OP_IDLE;
          nxt_st.done_flag = 1'b1;
          if (st_ff.long_op) begin
            nxt_st.buf_words = {nvmwp_pkg::BUF_WORDS{nvmwp_pkg::ERASED_WORD}};
          end
        end
      end
      nvmwp_pkg::OP_READ: begin
        if (mem_rd_valid) begin
          nxt_st.rd_start = 1'b0;
          nxt_st.op = nvmwp_pkg::OP_IDLE;
          nxt_st.data_lo = mem_rd_data[7:0];
          nxt_st.data_hi = st_ff.pgm_sel ? mem_rd_data[13:8] : '0;
        end
      end
      nvmwp_pkg::OP_IDLE: begin
        nxt_st.op = nxt_st.op;
      end
    endcase

    nxt_st.irq = nxt_st.done_flag && nxt_st.done_en;
    // busy kept in a flop so the pin never glitches on a state decode
    nxt_st.active = nxt_st.op == nvmwp_pkg::OP_WAIT;

    // external programming access, decided from synchronised pins
    nxt_st.deny = ext_rq && ((!ext_p && cfg_data_protect) ||
                             (ext_p && ext_w && cfg_data_protect) ||
                             (ext_p && cfg_code_protect));
    nxt_st.grant = ext_rq && !nxt_st.deny;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0;
      st_ff.unlock <= nvmwp_pkg::UNL_IDLE;
      st_ff.op <= nvmwp_pkg::OP_IDLE;
      st_ff.buf_words <= {nvmwp_pkg::BUF_WORDS{nvmwp_pkg::ERASED_WORD}};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reg_rdata = st_ff.rdata;
  assign mem_ee_write = st_ff.ee_wr;
  assign mem_flash_write = st_ff.fl_wr;
  assign mem_erase = st_ff.erase;
  assign mem_read = st_ff.rd_req;
  assign mem_is_program = st_ff.pgm_sel;
  assign mem_active = st_ff.active;
  assign mem_addr = st_ff.m_addr;
  assign mem_data = st_ff.m_data;
  assign mem_block_data = st_ff.buf_words;
  assign ext_grant = st_ff.grant;
  assign ext_deny = st_ff.deny;
  assign irq = st_ff.irq;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_start_needs_enable;
    (st_ff.ee_wr || st_ff.fl_wr || st_ff.erase) |-> $past(st_ff.wr_en);
  endproperty
  a_start_needs_enable: assert property (p_start_needs_enable) else $error("write launched without enable");

  property p_no_ee_during_pwrt;
    !st_ff.pwrt_done |-> !st_ff.ee_wr;
  endproperty
  a_no_ee_during_pwrt: assert property (p_no_ee_during_pwrt) else $error("eeprom write during power-up timer");

  property p_start_needs_unlock;
    $rose(st_ff.wr_start) |-> $past(st_ff.unlock) == nvmwp_pkg::UNL_ARMED;
  endproperty
  a_start_needs_unlock: assert property (p_start_needs_unlock) else $error("write launched while locked");

  property p_unlock_order;
    (reg_wr && reg_addr == nvmwp_pkg::OFS_UNLOCK && reg_wdata == nvmwp_pkg::KEY_SECOND &&
     st_ff.unlock == nvmwp_pkg::UNL_IDLE) |=> st_ff.unlock == nvmwp_pkg::UNL_IDLE;
  endproperty
  a_unlock_order: assert property (p_unlock_order) else $error("unlock armed out of order");

  property p_ext_ee_denied;
    (ext_rq && !ext_p && cfg_data_protect) |=> st_ff.deny && !st_ff.grant;
  endproperty
  a_ext_ee_denied: assert property (p_ext_ee_denied) else $error("external eeprom access not denied");

  property p_ext_pgm_write_denied;
    (ext_rq && ext_p && ext_w && cfg_data_protect) |=> st_ff.deny;
  endproperty
  a_ext_pgm_write_denied: assert property (p_ext_pgm_write_denied) else $error("external program write not denied");

  property p_self_protect;
    (ctl_wr && reg_wdata[nvmwp_pkg::BIT_WR_START] && st_ff.pgm_sel && self_blocked) |=> !st_ff.fl_wr && !st_ff.erase;
  endproperty
  a_self_protect: assert property (p_self_protect) else $error("protected region written");

  property p_long_at_last_word;
    st_ff.fl_wr |-> st_ff.m_addr[1:0] == nvmwp_pkg::LAST_IN_BLOCK && st_ff.op == nvmwp_pkg::OP_WAIT;
  endproperty
  a_long_at_last_word: assert property (p_long_at_last_word) else $error("long write at wrong address");

  property p_buffers_erased;
    (done_event && st_ff.long_op) |=> st_ff.buf_words == {nvmwp_pkg::BUF_WORDS{nvmwp_pkg::ERASED_WORD}};
  endproperty
  a_buffers_erased: assert property (p_buffers_erased) else $error("buffers not preset after long write");

  property p_done_irq;
    (done_event && st_ff.done_en && !reg_wr) |=> st_ff.done_flag && irq;
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("done flag or interrupt missing");

  property p_wr_en_by_software;
    $rose(st_ff.wr_en) |-> $past(ctl_wr);
  endproperty
  a_wr_en_by_software: assert property (p_wr_en_by_software) else $error("write enable set without a control write");
endmodule : nvmwp_ctrl

/* include/nvmwp_pkg.sv */
// constants, register map and state types of the nonvolatile write control block
// How it works
// - reset clears the write-enable bit, so no write starts until software sets it.
// - while the power-up timer runs, data EEPROM writes are refused.
// - a write starts only with write-enable set and the unlock sequence completed.
// - protected data EEPROM stays usable by the core but denies external access.
// - data EEPROM protection also denies external program memory writes.
// - self-writes blocked in regions chosen by protect bits; code protect denies external program access.
// - start at address low bits 11 launches the four-word long write; others buffer.
// - after each long write all four word buffers preset to 3FFF.
package nvmwp_pkg;
  // register offsets
  localparam logic [8:0] OFS_IRQ_FLAGS = 9'h00d;
  localparam logic [8:0] OFS_IRQ_EN = 9'h08d;
  localparam logic [8:0] OFS_DATA_LO = 9'h10c;
  localparam logic [8:0] OFS_ADDR_LO = 9'h10d;
  localparam logic [8:0] OFS_DATA_HI = 9'h10e;
  localparam logic [8:0] OFS_ADDR_HI = 9'h10f;
  localparam logic [8:0] OFS_CONTROL = 9'h18c;
  localparam logic [8:0] OFS_UNLOCK = 9'h18d;
  // control register fields
  localparam int BIT_PGM_SEL = 7;
  localparam int BIT_ERASE = 4;
  localparam int BIT_WR_ERR = 3;
  localparam int BIT_WR_EN = 2;
  localparam int BIT_WR_START = 1;
  localparam int BIT_RD_START = 0;
  // done flag and its enable share one position
  localparam int BIT_DONE = 4;
  // widths
  localparam int DATA_HI_W = 6;
  localparam int ADDR_HI_W = 3;
  localparam int WORD_W = 14;
  localparam int ADDR_W = 11;
  localparam int BUF_WORDS = 4;
  // unlock keys and erased word
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  localparam logic [13:0] ERASED_WORD = 14'h3fff;
  localparam logic [1:0] LAST_IN_BLOCK = 2'h3;
  // power-up timer
  localparam int PWRT_MS = 72;
  localparam int CLK_KHZ = 100000;
  localparam int PWRT_CYCLES_DEF = PWRT_MS * CLK_KHZ;
  localparam int PWRT_W = 23;
  // self-write protect: words below the limit are write protected
  localparam logic [1:0] WRT_NONE = 2'h3;
  localparam logic [1:0] WRT_LOW = 2'h2;
  localparam logic [1:0] WRT_MID = 2'h1;
  localparam logic [10:0] LIMIT_LOW = 11'h200;
  localparam logic [10:0] LIMIT_MID = 11'h400;
  localparam logic [10:0] LIMIT_ALL = 11'h7ff;
  typedef enum logic [1:0] {UNL_IDLE, UNL_FIRST, UNL_ARMED} nvmwp_unlock_type;
  typedef enum logic [1:0] {OP_IDLE, OP_SHORT, OP_WAIT, OP_READ} nvmwp_op_type;
endpackage : nvmwp_pkg

/* test/nvmwp_mem_model.sv */
// behavioural memory array that answers the write control block
`timescale 1ns/1ns
module nvmwp_mem_model #(
  parameter int LAT = 6
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // requests from the block
  input wire logic mem_ee_write,
  input wire logic mem_flash_write,
  input wire logic mem_erase,
  input wire logic mem_read,
  input wire logic [10:0] mem_addr,
  // answers
  output logic mem_done,
  output logic mem_rd_valid,
  output logic [13:0] mem_rd_data
);
  int cnt;
  logic rd_pend;
  logic [10:0] rd_addr;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cnt <= 0;
      mem_done <= 1'b0;
      rd_pend <= 1'b0;
      rd_addr <= 11'h000;
      mem_rd_valid <= 1'b0;
      mem_rd_data <= 14'h0000;
    end else begin
      mem_done <= (cnt == 1);
      if (mem_ee_write || mem_flash_write || mem_erase)
        cnt <= LAT;
      else if (cnt > 0)
        cnt <= cnt - 1;
      rd_pend <= mem_read;
      if (mem_read)
        rd_addr <= mem_addr;
      mem_rd_valid <= rd_pend;
      // data only meaningful with the valid pulse; toggles otherwise
      if (rd_pend)
        mem_rd_data <= {3'h5, rd_addr};
      else
        mem_rd_data <= ~mem_rd_data;
    end
  end
endmodule : nvmwp_mem_model

/* test/tb.sv */
// self-checking bench of the nonvolatile write control block
`timescale 1ns/1ns
module tb;
  localparam logic [8:0] A_FLG = nvmwp_pkg::OFS_IRQ_FLAGS;
  localparam logic [8:0] A_CTL = nvmwp_pkg::OFS_CONTROL;
  localparam logic [8:0] A_UNL = nvmwp_pkg::OFS_UNLOCK;
  localparam logic [8:0] A_DL = nvmwp_pkg::OFS_DATA_LO;
  localparam logic [8:0] A_DH = nvmwp_pkg::OFS_DATA_HI;
  localparam logic [8:0] A_AL = nvmwp_pkg::OFS_ADDR_LO;
  localparam logic [8:0] A_AH = nvmwp_pkg::OFS_ADDR_HI;
  logic clk, sys_rst, reg_wr, reg_rd, irq;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d;
  logic cfg_data_protect, cfg_code_protect;
  logic [1:0] self_write_protect_bits;
  logic mem_done, mem_rd_valid, mem_ee_write, mem_flash_write, mem_erase, mem_read, mem_is_program, mem_active;
  logic [13:0] mem_rd_data, mem_data, cap_data, w;
  logic [10:0] mem_addr, cap_addr, cap_faddr, fa;
  logic [55:0] mem_block_data, cap_blk, exp_blk;
  logic ext_req, ext_is_write, ext_is_program, ext_grant, ext_deny;
  int ee_cnt, fl_cnt, er_cnt, err_count, checked, n;
  logic [23:0] bad_tab [4] = '{{8'h55, 8'haa, 8'h02}, {8'h00, 8'h00, 8'h06}, {8'haa, 8'h55, 8'h06},
                                {8'h55, 8'h55, 8'h06}};
  // cp, protect bits, word address, start expected
  logic [14:0] fl_tab [4] = '{{3'h3, 11'h100, 1'b1}, {3'h6, 11'h100, 1'b0}, {3'h6, 11'h204, 1'b1},
                               {3'h4, 11'h7f0, 1'b0}};
  // data protect, code protect, write, program, deny expected
  logic [4:0] ext_tab [7] = '{5'h11, 5'h15, 5'h17, 5'h12, 5'h0b, 5'h0c, 5'h06};

  nvmwp_ctrl #(.PWRT_CYCLES(16)) u_nvmwp_ctrl (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cfg_data_protect(cfg_data_protect),
    .cfg_code_protect(cfg_code_protect), .self_write_protect_bits(self_write_protect_bits),
    .mem_done(mem_done), .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data),
    .mem_ee_write(mem_ee_write), .mem_flash_write(mem_flash_write), .mem_erase(mem_erase),
    .mem_read(mem_read), .mem_is_program(mem_is_program), .mem_active(mem_active), .mem_addr(mem_addr),
    .mem_data(mem_data), .mem_block_data(mem_block_data), .ext_req(ext_req), .ext_is_write(ext_is_write),
    .ext_is_program(ext_is_program), .ext_grant(ext_grant), .ext_deny(ext_deny), .irq(irq));
  nvmwp_mem_model u_nvmwp_mem_model (
    .clk(clk), .sys_rst(sys_rst), .mem_ee_write(mem_ee_write), .mem_flash_write(mem_flash_write),
    .mem_erase(mem_erase), .mem_read(mem_read), .mem_addr(mem_addr), .mem_done(mem_done),
    .mem_rd_valid(mem_rd_valid), .mem_rd_data(mem_rd_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (mem_ee_write === 1'b1) begin
      ee_cnt <= ee_cnt + 1;
      cap_addr <= mem_addr;
      cap_data <= mem_data;
    end
    if (mem_flash_write === 1'b1) begin
      fl_cnt <= fl_cnt + 1;
      cap_faddr <= mem_addr;
      cap_blk <= mem_block_data;
    end
    if (mem_erase === 1'b1) begin
      er_cnt <= er_cnt + 1;
    end
  end

  task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  // enable bit goes in first: it must already stand when the start arrives
  task automatic start_seq(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] c);
    wr(A_CTL, c & 8'hfd);
    wr(A_UNL, k1);
    wr(A_UNL, k2);
    wr(A_CTL, c);
  endtask : start_seq
  task automatic settle();
    repeat (3) @(posedge clk);
    for (int i = 0; i < 200 && mem_active !== 1'b0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1;
  endtask : settle
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    summarize();
  end

  initial begin
    {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 19'h0_0000};
    {cfg_data_protect, cfg_code_protect, self_write_protect_bits} = 4'h3;
    {ext_req, ext_is_write, ext_is_program, ee_cnt, fl_cnt, er_cnt, err_count, checked} = '0;
    repeat (20) @(posedge clk);
    sys_rst <= 1'b0;
    // data EEPROM writes must be refused while the power-up timer runs
    start_seq(8'h55, 8'haa, 8'h06);
    repeat (4) @(posedge clk);
    chk("writes in power-up", 0, ee_cnt);
    rd(A_CTL, d);
    chk("refused start error", 8'h0c, d & 8'h0e);
    $display("power-up test done");
    repeat (20) @(posedge clk);
    foreach (bad_tab[t]) begin
      n = ee_cnt;
      start_seq(bad_tab[t][23:16], bad_tab[t][15:8], bad_tab[t][7:0]);
      settle();
      chk("refused start", n, ee_cnt);
    end
    $display("refusal test done");
    for (int en = 1; en >= 0; en--) begin
      // core writes stay allowed under data protection
      cfg_data_protect <= (en == 0);
      wr(nvmwp_pkg::OFS_IRQ_EN, en ? 8'h10 : 8'h00);
      wr(A_AL, 8'h12 + en);
      wr(A_DL, 8'h5a);
      wr(A_DH, 8'h15);
      n = ee_cnt;
      start_seq(8'h55, 8'haa, 8'h06);
      settle();
      chk("eeprom starts", n + 1, ee_cnt);
      chk("eeprom address", 11'h012 + en, cap_addr);
      chk("eeprom data", 14'h155a, cap_data);
      chk("irq", en, irq);
      rd(A_FLG, d);
      chk("done flag", 8'h10, d & 8'h10);
      rd(A_FLG, d);
      chk("done cleared", 8'h00, d & 8'h10);
      chk("irq cleared", 0, irq);
    end
    $display("eeprom test done");
    cfg_data_protect <= 1'b0;
    foreach (fl_tab[t]) begin
      {cfg_code_protect, self_write_protect_bits} <= fl_tab[t][14:12];
      fa = fl_tab[t][11:1];
      n = fl_cnt;
      wr(A_AH, {5'h00, fa[10:8]});
      for (int i = 0; i < 4; i++) begin
        w = {6'h15 + i[5:0], 8'hc3 ^ i[7:0]};
        exp_blk[14*i+:14] = w;
        wr(A_AL, {fa[7:2], i[1:0]});
        wr(A_DL, w[7:0]);
        wr(A_DH, {2'h0, w[13:8]});
        // software side repeats load, unlock and start for every word
        start_seq(8'h55, 8'haa, 8'h86);
        settle();
        if (i < 3)
          chk("short write", n, fl_cnt);
      end
      chk("long write", n + fl_tab[t][0], fl_cnt);
      if (fl_tab[t][0]) begin
        chk("block address", fa[10:2], cap_faddr[10:2]);
        chk("block data", exp_blk, cap_blk);
        chk("buffers erased", {4{nvmwp_pkg::ERASED_WORD}}, mem_block_data);
      end
    end
    $display("flash test done");
    // row erase refused in a protected region, accepted once the region is opened
    for (int p = 0; p < 2; p++) begin
      self_write_protect_bits <= p ? 2'h3 : 2'h0;
      n = er_cnt;
      start_seq(8'h55, 8'haa, 8'h96);
      @(posedge clk);
      #1;
      chk("erase busy", p, mem_active);
      settle();
      chk("row erase", n + p, er_cnt);
      chk("program select", 1, mem_is_program);
    end
    $display("erase test done");
    wr(A_AH, 8'h02);
    wr(A_AL, 8'h4d);
    wr(A_CTL, 8'h81);
    repeat (8) @(posedge clk);
    rd(A_DL, d);
    chk("read low", 8'h4d, d);
    rd(A_DH, d);
    chk("read high", 8'h2a, d);
    $display("read test done");
    foreach (ext_tab[t]) begin
      {cfg_data_protect, cfg_code_protect, ext_is_write, ext_is_program} <= ext_tab[t][4:1];
      ext_req <= 1'b1;
      repeat (5) @(posedge clk);
      #1;
      chk("ext deny", ext_tab[t][0], ext_deny);
      chk("ext grant", !ext_tab[t][0], ext_grant);
      ext_req <= 1'b0;
      repeat (5) @(posedge clk);
    end
    $display("external test done");
    // leave a loaded buffer word and the enable bit set, so reset has work to undo
    self_write_protect_bits <= 2'h3;
    start_seq(8'h55, 8'haa, 8'h86);
    settle();
    chk("short fill", 14'h2a4d, mem_block_data[27:14]);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(A_CTL, d);
    chk("enable after reset", 8'h00, d & 8'h07);
    chk("buffers after reset", {4{nvmwp_pkg::ERASED_WORD}}, mem_block_data);
    $display("reset test done");
    summarize();
  end
endmodule : tb
